// ===== design/lf_receiver_sample_scheduler.sv
// duty-cycle scheduler of the lf wake-up receiver with its apb registers
// Function
// (RL1) timing register: interval select in 7:4, on-time select in 3:0, both rw
// (RL2) interval code 0000 keeps the receiver continuously on
// (RL3) codes 0001..0100 start windows every 16, 32, 64, 128 lf periods
// (RL4) doubling continues up to code 1001, every 4096 lf periods
// (RL5) reset loads interval select with 0110, 512 lf periods
// (RL6) after writing interval select, first interval starts on next lf tick
// (RL7) detector on at each interval start; code 0000 is one cycle, doubling
// (RL8) on-time code 0110 is 64 cycles, doubling up to 1024
// (RL9) on-time is net; up to 2 ms initialization sits in preceding off time
// (RL10) carrier detect mode switches detector off once carrier evaluation ends; here periodic mode only, interval code 0000 keeps it on
// (RL11) data receive mode extends on-time until message end, error or timeout
// (RL12) reset clears on-time select to zero, the shortest window
// (RL13) control bit selects mode: zero data receive, one carrier detect
// (RL14) software changes control registers only while receiver is disabled
// (RL15) continuous mode restarts itself 2-3 lf periods after a processed signal
// (RL16) interval and on-time counters run on lf ticks, reloaded each boundary
`timescale 1ns/10ps
`default_nettype none
module lf_receiver_sample_scheduler import lf_sched_pkg::*; #(
	parameter int TICK_DIV = LF_TICK_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// detector and decoder events, one-cycle pulses
	input wire logic signal_detected_in,
	input wire logic carrier_eval_done_in,
	input wire logic message_end_in,
	input wire logic decode_error_in,
	input wire logic processed_ok_in,
	// detector control
	output logic detector_on_out,
	output logic detector_init_out,
	output logic window_start_out
);
	// software registers and the restart request
	logic [7:0] timing_q;
	logic [7:0] timing_d;
	logic [1:0] ctrl_q;
	logic [1:0] ctrl_d;
	logic pend_q;
	// scheduler state and counters
	sched_state_t state_q;
	sched_state_t state_d;
	logic [11:0] ivl_cnt_q;
	logic [11:0] ivl_cnt_d;
	logic [9:0] on_cnt_q;
	logic [9:0] on_cnt_d;
	logic [7:0] tmo_cnt_q;
	logic [7:0] tmo_cnt_d;
	logic [1:0] gap_cnt_q;
	logic [1:0] gap_cnt_d;
	// next values of the registered outputs
	logic [31:0] prdata_d;
	logic pslverr_d;
	logic det_on_d;
	logic det_start_d;
	logic init_d;
	// internal strobes
	logic start_d;
	logic lf_tick;

	// oscillator tick source
	lf_tick_gen #(
		.TICK_DIV(TICK_DIV)
	) u_tick (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.tick_out(lf_tick)
	);

	// apb decode; unmapped addresses answer with pslverr and zero data
	wire setup_phase = psel_in & ~penable_in;
	wire access_done = psel_in & penable_in & pready_out;
	wire hit_ctrl = (paddr_in == CTRL_ADDR);
	wire hit_timing = (paddr_in == TIMING_ADDR);
	wire hit_status = (paddr_in == STATUS_ADDR);
	wire hit_any = hit_ctrl | hit_timing | hit_status;
	wire wr_ctrl = access_done & pwrite_in & hit_ctrl;
	wire wr_timing = access_done & pwrite_in & hit_timing;

	// field views
	wire [3:0] ivl_code = timing_q[INTERVAL_LSB +: 4]; // RL1
	wire [3:0] on_code = timing_q[ONTIME_LSB +: 4]; // RL1
	wire enabled = ctrl_q[CTRL_EN_BIT];
	wire carrier_mode = ctrl_q[CTRL_CARRIER_BIT]; // RL13
	wire continuous = (ivl_code == INTERVAL_CONT); // RL2
	wire new_ivl = wr_timing & (pwdata_in[INTERVAL_LSB +: 4] != ivl_code);
	wire en_rise = wr_ctrl & pwdata_in[CTRL_EN_BIT] & ~enabled;

	// interval length minus one: 8 shifted by code, codes above 1001 clamp
	wire [3:0] ivl_sel = (ivl_code > INTERVAL_MAX_CODE) ? INTERVAL_MAX_CODE : ivl_code;
	wire [11:0] ivl_reload = (INTERVAL_BASE << ivl_sel) - 12'h001; // RL3 RL4
	// on-time minus one: 1 shifted by code, codes above 1010 clamp
	wire [3:0] on_sel = (on_code > ONTIME_MAX_CODE) ? ONTIME_MAX_CODE : on_code;
	wire [10:0] on_full = (ONTIME_BASE << on_sel) - 11'h001;
	wire [9:0] on_reload = on_full[9:0]; // RL7 RL8

	// counter end points and the periodic interval boundary
	wire ivl_last = (ivl_cnt_q == 12'h000);
	wire on_last = (on_cnt_q == 10'h000);
	wire tmo_last = (tmo_cnt_q == 8'h00);
	wire gap_last = (gap_cnt_q == 2'h0);
	wire periodic_tick = ~continuous & lf_tick;
	wire boundary = periodic_tick & ivl_last;

	// counter decrements, used only away from the end points
	wire [11:0] ivl_dec = ivl_cnt_q - 12'h001;
	wire [9:0] on_dec = on_cnt_q - 10'h001;
	wire [7:0] tmo_dec = tmo_cnt_q - 8'h01;
	wire [1:0] gap_dec = gap_cnt_q - 2'h1;

	// read mux; status shows the scheduler's own state
	wire st_ext = (state_q == ST_EXTEND);
	wire st_gap = (state_q == ST_GAP);
	wire [31:0] status_word = {26'h000_0000, continuous, st_gap, st_ext,
		detector_init_out, detector_on_out, pend_q};
	wire [31:0] rdata = hit_ctrl ? {30'h0000_0000, ctrl_q} :
		hit_timing ? {24'h00_0000, timing_q} :
		hit_status ? status_word : 32'h0000_0000;

	// read data stands only in the access cycle of a read and is zero otherwise
	wire rd_setup = setup_phase & ~pwrite_in;
	assign prdata_d = rd_setup ? rdata : 32'h0000_0000;
	assign pslverr_d = setup_phase & ~hit_any;

	// apb answer: one wait-free access phase after every setup cycle
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= setup_phase;
			prdata_out <= prdata_d;
			pslverr_out <= pslverr_d;
		end
	end

	// writes land at the access edge only; upper data bits are dropped
	assign timing_d = wr_timing ? pwdata_in[7:0] : timing_q; // RL1 RL14
	assign ctrl_d = wr_ctrl ? pwdata_in[1:0] : ctrl_q; // RL13 RL14

	// software registers; the design relies on changes made while disabled
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			timing_q <= TIMING_RESET; // RL5 RL12
			ctrl_q <= CTRL_RESET;
		end else begin
			timing_q <= timing_d;
			ctrl_q <= ctrl_d;
		end
	end

	// restart request: a new interval or an enable waits for the next tick
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			pend_q <= 1'b0;
		end else if (new_ivl | en_rise) begin
			pend_q <= 1'b1; // RL6
		end else if (lf_tick | ~enabled) begin
			pend_q <= 1'b0;
		end
	end

	// next-state logic of the scheduler
	always_comb begin
		state_d = state_q;
		ivl_cnt_d = ivl_cnt_q;
		on_cnt_d = on_cnt_q;
		tmo_cnt_d = tmo_cnt_q;
		gap_cnt_d = gap_cnt_q;
		start_d = 1'b0;
		if (~enabled) begin
			state_d = ST_IDLE;
		end else if (pend_q & lf_tick) begin
			// first interval begins right on this tick
			state_d = ST_ON; // RL6
			ivl_cnt_d = ivl_reload; // RL16
			on_cnt_d = on_reload; // RL16
			start_d = 1'b1;
		end else if (~pend_q) begin
			// interval boundary reloads both counters, periodic mode only
			if (periodic_tick) begin
				if (ivl_last) begin
					ivl_cnt_d = ivl_reload; // RL16
					on_cnt_d = on_reload; // RL16
					start_d = 1'b1;
				end else begin
					ivl_cnt_d = ivl_dec; // RL16
				end
			end
			case (state_q)
				ST_IDLE: begin
					state_d = ST_IDLE;
				end
				ST_OFF: begin
					if (continuous) begin
						state_d = ST_ON; // RL2
					end else if (boundary) begin
						state_d = ST_ON; // RL7
					end
				end
				ST_ON: begin
					if (continuous & processed_ok_in) begin
						state_d = ST_GAP; // RL15
						gap_cnt_d = GAP_TICKS;
					end else if (carrier_mode & carrier_eval_done_in & ~continuous) begin
						state_d = ST_OFF; // RL10
					end else if (~carrier_mode & signal_detected_in) begin
						state_d = ST_EXTEND; // RL11
						tmo_cnt_d = DATA_TIMEOUT_TICKS;
					end else if (periodic_tick) begin
						// at a boundary the reload above stands, so a window may span it
						if (on_last) begin
							state_d = boundary ? ST_ON : ST_OFF; // RL7
						end else if (~boundary) begin
							on_cnt_d = on_dec; // RL16
						end
					end
				end
				ST_EXTEND: begin
					// stays on past the window until the message settles
					if (continuous & processed_ok_in) begin
						state_d = ST_GAP; // RL15
						gap_cnt_d = GAP_TICKS;
					end else if (message_end_in | decode_error_in) begin
						state_d = (continuous | boundary) ? ST_ON : ST_OFF; // RL11
					end else if (lf_tick) begin
						if (tmo_last) begin
							state_d = (continuous | boundary) ? ST_ON : ST_OFF; // RL11
						end else begin
							tmo_cnt_d = tmo_dec;
						end
					end
				end
				ST_GAP: begin
					// partial first period makes the gap 2 to 3 periods long
					if (lf_tick) begin
						if (gap_last) begin
							state_d = ST_ON; // RL15
						end else begin
							gap_cnt_d = gap_dec;
						end
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	// initialization runs in the last ticks of the off time before a window
	assign init_d = (state_d == ST_OFF) & ~continuous &
		(ivl_cnt_d < INIT_TICKS); // RL9

	// scheduler registers
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			state_q <= ST_IDLE;
			ivl_cnt_q <= 12'h000;
			on_cnt_q <= 10'h000;
			tmo_cnt_q <= 8'h00;
			gap_cnt_q <= 2'h0;
		end else begin
			state_q <= state_d;
			ivl_cnt_q <= ivl_cnt_d;
			on_cnt_q <= on_cnt_d;
			tmo_cnt_q <= tmo_cnt_d;
			gap_cnt_q <= gap_cnt_d;
		end
	end

	// the detector is powered in the window and while a message is followed
	assign det_on_d = (state_d == ST_ON) | (state_d == ST_EXTEND); // RL7 RL11
	// an extension running over a boundary gives no start pulse
	assign det_start_d = start_d & (state_d == ST_ON);

	// detector outputs, registered from the next state so they line up with the state register
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			detector_on_out <= 1'b0;
			detector_init_out <= 1'b0;
			window_start_out <= 1'b0;
		end else begin
			detector_on_out <= det_on_d; // RL7
			detector_init_out <= init_d; // RL9
			window_start_out <= det_start_d;
		end
	end
endmodule : lf_receiver_sample_scheduler
`default_nettype wire

// ===== design/lf_sched_pkg.sv
// constants, register map and state type for the lf sampling scheduler
package lf_sched_pkg;
	// clock and low-frequency oscillator timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int LF_PERIOD_NS = 1_000_000;
	localparam int LF_TICK_CYCLES = LF_PERIOD_NS / CLK_PERIOD_NS;
	// detector initialization before each on window, in ms and in lf ticks
	localparam int INIT_MS = 2;
	localparam int LF_PERIOD_MS = 1;
	localparam logic [11:0] INIT_TICKS = 12'(INIT_MS / LF_PERIOD_MS);
	// continuous mode restart gap and data receive timeout, in lf ticks
	localparam logic [1:0] GAP_TICKS = 2'h2;
	localparam logic [7:0] DATA_TIMEOUT_TICKS = 8'h40;

	// register indices; byte address is four times the index
	localparam logic [7:0] CTRL_IDX = 8'h20;
	localparam logic [7:0] TIMING_IDX = 8'h21;
	localparam logic [7:0] STATUS_IDX = 8'h22;
	localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [11:0] TIMING_ADDR = {2'h0, TIMING_IDX, 2'h0};
	localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};

	// timing register fields and reset value
	localparam int INTERVAL_LSB = 4;
	localparam int ONTIME_LSB = 0;
	localparam logic [7:0] TIMING_RESET = 8'h60;
	localparam logic [3:0] INTERVAL_CONT = 4'h0;
	localparam logic [3:0] INTERVAL_MAX_CODE = 4'h9;
	localparam logic [3:0] ONTIME_MAX_CODE = 4'ha;
	localparam logic [11:0] INTERVAL_BASE = 12'h008;
	localparam logic [10:0] ONTIME_BASE = 11'h001;

	// control register fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_CARRIER_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// scheduler states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OFF,
		ST_ON,
		ST_EXTEND,
		ST_GAP
	} sched_state_t;
endpackage : lf_sched_pkg

// ===== design/lf_tick_gen.sv
// divider that turns the system clock into one-cycle low-frequency ticks
`timescale 1ns/10ps
`default_nettype none
module lf_tick_gen #(
	parameter int TICK_DIV = 40000
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// tick output
	output logic tick_out
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic wrap;

	// a tick every TICK_DIV clocks stands in for one oscillator period
	assign wrap = (cnt_q == 32'(TICK_DIV - 1));
	assign cnt_d = wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001;

	// counter and registered tick
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cnt_q <= 32'h0000_0000;
			tick_out <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_out <= wrap;
		end
	end
endmodule : lf_tick_gen
`default_nettype wire

// ===== verif/lf_receiver_sample_scheduler_assertions.sv
// port-level assertions for the lf sampling scheduler
`timescale 1ns/10ps
`default_nettype none
module lf_sched_checker import lf_sched_pkg::*; #(
	parameter int TICK_DIV = LF_TICK_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// apb
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	// events and detector control
	input wire logic carrier_eval_done_in,
	input wire logic processed_ok_in,
	input wire logic detector_on_out,
	input wire logic detector_init_out,
	input wire logic window_start_out
);
	logic [7:0] tim_q;
	logic [1:0] ctl_q;
	logic wr_acc;
	logic mapped;
	// decode of completed writes and of the three mapped words
	assign wr_acc = psel_in && penable_in && pready_out && pwrite_in;
	assign mapped = paddr_in == CTRL_ADDR || paddr_in == TIMING_ADDR || paddr_in == STATUS_ADDR;
	// shadow copies, so mode-dependent checks need no access to the design's state
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			tim_q <= TIMING_RESET;
			ctl_q <= CTRL_RESET;
		end else if (wr_acc && paddr_in == TIMING_ADDR) begin
			tim_q <= pwdata_in[7:0];
		end else if (wr_acc && paddr_in == CTRL_ADDR) begin
			ctl_q <= pwdata_in[1:0];
		end
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	property p_ready_next;
		psel_in && !penable_in |=> pready_out;
	endproperty
	a_ready_next: assert property (p_ready_next)
		else $error("no ready after setup");
	property p_ready_single;
		pready_out |=> !pready_out;
	endproperty
	a_ready_single: assert property (p_ready_single)
		else $error("ready longer than one cycle");
	property p_err_map;
		pready_out |-> pslverr_out == !mapped;
	endproperty
	a_err_map: assert property (p_err_map)
		else $error("error flag wrong for address");
	property p_start_on;
		window_start_out |-> detector_on_out;
	endproperty
	a_start_on: assert property (p_start_on)
		else $error("window start without detector on");
	property p_init_off;
		detector_init_out |-> !detector_on_out;
	endproperty
	a_init_off: assert property (p_init_off)
		else $error("init overlaps on window");
	property p_start_gap;
		window_start_out |=> (!window_start_out) [*8];
	endproperty
	a_start_gap: assert property (p_start_gap)
		else $error("window starts too close");
	property p_rst_quiet;
		disable iff (1'b0) sys_rst_in |=> !detector_on_out && !window_start_out && !pready_out;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("outputs active after reset");
	property p_carrier_off;
		ctl_q == 2'b11 && tim_q[7:4] != INTERVAL_CONT && detector_on_out && carrier_eval_done_in
			&& !window_start_out |-> ##[1:2] !detector_on_out;
	endproperty
	a_carrier_off: assert property (p_carrier_off)
		else $error("detector on after carrier evaluation");
	property p_disable_off;
		wr_acc && paddr_in == CTRL_ADDR && !pwdata_in[CTRL_EN_BIT] |-> ##[1:2] !detector_on_out;
	endproperty
	a_disable_off: assert property (p_disable_off)
		else $error("detector on after disable");
	property p_cont_gap;
		ctl_q[0] && tim_q[7:4] == INTERVAL_CONT && detector_on_out && processed_ok_in
			|=> ##1 (!detector_on_out) [*8];
	endproperty
	a_cont_gap: assert property (p_cont_gap)
		else $error("continuous restart gap too short");
endmodule : lf_sched_checker
bind lf_receiver_sample_scheduler lf_sched_checker #(.TICK_DIV(TICK_DIV)) u_chk (.ref_clk_in,
	.sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out,
	.pslverr_out, .carrier_eval_done_in, .processed_ok_in, .detector_on_out,
	.detector_init_out, .window_start_out);
`default_nettype wire

// ===== verif/lf_receiver_sample_scheduler_tb.sv
// self-checking bench for the lf sampling scheduler
`timescale 1ns/10ps
`default_nettype none
module lf_receiver_sample_scheduler_tb import lf_sched_pkg::*;;
	localparam int TD = 8;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0000_0000;
	logic [4:0] ev = 5'h00;
	logic [31:0] prdata_out;
	logic pready_out, pslverr_out, detector_on_out, detector_init_out, window_start_out;
	logic [31:0] rd;
	logic err, ini;
	logic [7:0] tv [5] = '{8'h10, 8'h21, 8'h32, 8'h46, 8'h9a};
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	int n, m;
	lf_receiver_sample_scheduler #(.TICK_DIV(TD)) DUT (.ref_clk_in, .sys_rst_in, .psel_in,
		.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
		.signal_detected_in(ev[0]), .carrier_eval_done_in(ev[1]), .message_end_in(ev[2]),
		.decode_error_in(ev[3]), .processed_ok_in(ev[4]), .detector_on_out, .detector_init_out,
		.window_start_out);
	initial begin
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	task give_verdict;
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	// the longest case spans about 33k clocks, so this only catches a hang
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			$display("Error at %0t: timeout", $time);
			give_verdict;
		end
	end
	task chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			fails++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : chk
	// one apb transfer; request held until ready is seen at an edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		do @(posedge ref_clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	task rdchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd === x && err === xe, "read value");
	endtask : rdchk
	// settings change only while disabled, with a settle time after disabling, before the timing write
	task cfg(input logic [7:0] t, input logic [1:0] c);
		apb(1'b1, CTRL_ADDR, 32'h0000_0000);
		repeat (2 * TD) @(posedge ref_clk_in);
		apb(1'b1, TIMING_ADDR, {24'h00_0000, t});
		apb(1'b1, CTRL_ADDR, {30'h0000_0000, c});
	endtask : cfg
	task wstart(output int k);
		k = 0;
		do begin
			@(posedge ref_clk_in);
			k++;
			ini |= detector_init_out;
		end while (window_start_out !== 1'b1 && k < 40000);
	endtask : wstart
	task pulse(input int i);
		@(posedge ref_clk_in);
		ev[i] <= 1'b1;
		@(posedge ref_clk_in);
		ev[i] <= 1'b0;
	endtask : pulse
	initial begin
		repeat (4) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		rdchk(TIMING_ADDR, 32'h0000_0060, 1'b0);
		rdchk(CTRL_ADDR, 32'h0000_0000, 1'b0);
		apb(1'b1, TIMING_ADDR, 32'hffff_ffa5);
		rdchk(TIMING_ADDR, 32'h0000_00a5, 1'b0);
		rdchk(12'h090, 32'h0000_0000, 1'b1);
		// period and on length per interval and on-time code
		for (int i = 0; i < 5; i++) begin
			cfg(tv[i], 2'b01);
			wstart(n);
			chk(n <= TD + 2, "first window late");
			ini = 1'b0;
			m = 0;
			do begin
				@(posedge ref_clk_in);
				m++;
			end while (detector_on_out === 1'b1 && m < 40000);
			chk(m >= (1 << tv[i][3:0]) * TD - 1 && m <= (1 << tv[i][3:0]) * TD + 1, "on");
			wstart(n);
			chk(m + n == (8 << tv[i][7:4]) * TD, "interval");
			chk(ini, "no init before window");
		end
		// data mode extension ended by message end, then by decode error
		for (int e = 2; e <= 3; e++) begin
			cfg(8'h11, 2'b01);
			wstart(n);
			pulse(0);
			repeat (4 * TD) @(posedge ref_clk_in);
			chk(detector_on_out === 1'b1, "not extended");
			pulse(e);
			repeat (3) @(posedge ref_clk_in);
			chk(detector_on_out === 1'b0, "extension not ended");
		end
		// data mode extension with no end runs out after the timeout
		cfg(8'h41, 2'b01);
		wstart(n);
		pulse(0);
		repeat ((DATA_TIMEOUT_TICKS - 4) * TD) @(posedge ref_clk_in);
		chk(detector_on_out === 1'b1, "extension ended early");
		repeat (6 * TD) @(posedge ref_clk_in);
		chk(detector_on_out === 1'b0, "extension timeout missing");
		cfg(8'h12, 2'b11);
		wstart(n);
		pulse(1);
		repeat (3) @(posedge ref_clk_in);
		chk(detector_on_out === 1'b0, "carrier not early off");
		cfg(8'h00, 2'b01);
		repeat (4 * TD) @(posedge ref_clk_in);
		chk(detector_on_out === 1'b1, "continuous not on");
		rdchk(STATUS_ADDR, 32'h0000_0022, 1'b0);
		pulse(4);
		m = 0;
		do begin
			@(posedge ref_clk_in);
			m++;
		end while (detector_on_out !== 1'b1 && m < 100);
		chk(m >= 2 * TD && m <= 3 * TD + 3, "restart gap");
		give_verdict;
	end
endmodule : lf_receiver_sample_scheduler_tb
`default_nettype wire
